//--- src/cmg_guard.sv
// CPU mode tracker and memory/register access guard
`timescale 1ns/1ps
`default_nettype none

module cmg_guard (
    // Clock and reset
    input  wire logic                     mclk,
    input  wire logic                     nrst,
    // Register access from the CPU
    input  wire logic                     sfrRd,
    input  wire logic                     sfrWr,
    input  wire logic [7:0]               sfrAddr,
    input  wire logic [7:0]               sfrWdata,
    output logic      [7:0]               sfrRdata,
    output logic                          sfrDenied,
    // Memory access from the CPU
    input  wire logic                     memReq,
    input  wire logic                     memWr,
    input  wire logic [15:0]              memAddr,
    input  wire logic                     segAllowRd,
    input  wire logic                     segAllowWr,
    input  wire logic                     segAllowHw,
    output logic                          memGrant,
    output logic                          memWrGrant,
    // Mode change events
    input  wire logic                     callValid,
    input  wire logic [15:0]              callTarget,
    input  wire logic                     excEntry,
    input  wire logic                     retInstr,
    // Mode and table state
    output logic      [2:0]               cpuMode,
    output logic      [15:0]              segTableAddr
);

    cmg_pkg::cmg_mode_type                modeReg, modeNext;
    cmg_pkg::cmg_mode_type                stackReg [cmg_pkg::STACK_D];
    cmg_pkg::cmg_mode_type                stackNext [cmg_pkg::STACK_D];
    logic [1:0]                           spReg, spNext;
    logic [15:0]                          tblReg, tblNext;
    logic [7:0]                           rdReg, rdNext;
    logic                                 denReg, denNext;
    logic                                 grantReg, grantNext;
    logic                                 wgrantReg, wgrantNext;
    cmg_pkg::cmg_group_type               grp;
    logic                                 canRd, canWr, inPart, reqMode;
    cmg_pkg::cmg_mode_type                wrMode;

    // Group decode, fixed in hardware
    always_comb begin
        if (sfrAddr == cmg_pkg::SFR_TBL_LOW || sfrAddr == cmg_pkg::SFR_TBL_HIGH) begin
            grp = cmg_pkg::GRP_SEGCFG;
        end else if (sfrAddr >= cmg_pkg::SFR_CPU_LO && sfrAddr <= cmg_pkg::SFR_CPU_HI) begin
            grp = cmg_pkg::GRP_CPU;
        end else if (sfrAddr >= cmg_pkg::SFR_SYS_LO && sfrAddr <= cmg_pkg::SFR_SYS_HI) begin
            grp = cmg_pkg::GRP_SYSMGMT;
        end else if (sfrAddr >= cmg_pkg::SFR_HW_LO) begin
            grp = cmg_pkg::GRP_HWCOMP;
        end else begin
            grp = cmg_pkg::GRP_NONE;
        end
    end

    // Per-mode register permission
    always_comb begin
        canRd = 1'b0;
        canWr = 1'b0;
        case (modeReg)
            cmg_pkg::MODE_BOOT, cmg_pkg::MODE_TEST: begin
                canRd = (grp != cmg_pkg::GRP_NONE);
                canWr = (grp != cmg_pkg::GRP_NONE);
            end
            cmg_pkg::MODE_SYSTEM: begin
                canRd = (grp != cmg_pkg::GRP_NONE);
                canWr = (grp != cmg_pkg::GRP_NONE);
            end
            cmg_pkg::MODE_CONTACTLESS: begin
                canRd = grp == cmg_pkg::GRP_CPU || grp == cmg_pkg::GRP_HWCOMP
                        || sfrAddr == cmg_pkg::SFR_STATUS_HIGH;
                canWr = grp == cmg_pkg::GRP_CPU || grp == cmg_pkg::GRP_HWCOMP;
            end
            default: begin
                canRd = grp == cmg_pkg::GRP_CPU
                        || (grp == cmg_pkg::GRP_HWCOMP && segAllowHw)
                        || sfrAddr == cmg_pkg::SFR_STATUS_HIGH;
                canWr = grp == cmg_pkg::GRP_CPU
                        || (grp == cmg_pkg::GRP_HWCOMP && segAllowHw);
            end
        endcase
    end

    // Memory partition and segment rights
    always_comb begin
        inPart = memAddr >= cmg_pkg::PART_CL_LO && memAddr <= cmg_pkg::PART_CL_HI;
        case (modeReg)
            cmg_pkg::MODE_CONTACTLESS: reqMode = inPart;
            cmg_pkg::MODE_SYSTEM:      reqMode = !inPart;
            cmg_pkg::MODE_USER: begin
                reqMode = !inPart && (memWr ? segAllowWr : segAllowRd);
            end
            default:                   reqMode = 1'b1;
        endcase
    end

    // Mode written through status-high
    always_comb begin
        case (sfrWdata[cmg_pkg::MODE_POS +: 3])
            3'h0:    wrMode = cmg_pkg::MODE_BOOT;
            3'h1:    wrMode = cmg_pkg::MODE_TEST;
            3'h2:    wrMode = cmg_pkg::MODE_CONTACTLESS;
            3'h3:    wrMode = cmg_pkg::MODE_SYSTEM;
            default: wrMode = cmg_pkg::MODE_USER;
        endcase
    end

    // Next state: mode, stack, table, answers
    always_comb begin
        modeNext   = modeReg;
        stackNext  = stackReg;
        spNext     = spReg;
        tblNext    = tblReg;
        rdNext     = cmg_pkg::ZERO_BYTE;
        denNext    = 1'b0;
        grantNext  = memReq && reqMode;
        wgrantNext = memReq && memWr && reqMode;
        if (sfrWr && canWr) begin
            if (sfrAddr == cmg_pkg::SFR_TBL_LOW) tblNext[7:0] = sfrWdata;
            if (sfrAddr == cmg_pkg::SFR_TBL_HIGH) tblNext[15:8] = sfrWdata;
            if (sfrAddr == cmg_pkg::SFR_STATUS_HIGH) modeNext = wrMode;
        end else if (sfrWr) begin
            denNext = 1'b1;
        end
        if (sfrRd) begin
            denNext = !canRd;
            if (canRd && sfrAddr == cmg_pkg::SFR_TBL_LOW) rdNext = tblReg[7:0];
            if (canRd && sfrAddr == cmg_pkg::SFR_TBL_HIGH) rdNext = tblReg[15:8];
            if (canRd && sfrAddr == cmg_pkg::SFR_STATUS_HIGH) begin
                rdNext = {5'b0_0000, modeReg};
            end
        end
        if (retInstr) begin
            spNext   = spReg - 2'd1;
            modeNext = stackReg[spNext];
        end else if (excEntry || (callValid && ((callTarget >= cmg_pkg::SYSTEM_VECTOR_ADDRESS_LO
                     && callTarget <= cmg_pkg::SYSTEM_VECTOR_ADDRESS_HI) || callTarget == cmg_pkg::SCALL_A
                     || callTarget == cmg_pkg::SCALL_B))) begin
            stackNext[spReg] = modeReg;
            spNext   = spReg + 2'd1;
            modeNext = cmg_pkg::MODE_SYSTEM;
        end
    end

    // State registers, restrictive defaults only
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            modeReg   <= cmg_pkg::MODE_SYSTEM;
            spReg     <= 2'd0;
            tblReg    <= cmg_pkg::TBL_RESET;
            rdReg     <= cmg_pkg::ZERO_BYTE;
            denReg    <= 1'b0;
            grantReg  <= 1'b0;
            wgrantReg <= 1'b0;
            for (int i = 0; i < cmg_pkg::STACK_D; i++) begin
                stackReg[i] <= cmg_pkg::MODE_SYSTEM;
            end
        end else begin
            modeReg   <= modeNext;
            spReg     <= spNext;
            tblReg    <= tblNext;
            rdReg     <= rdNext;
            denReg    <= denNext;
            grantReg  <= grantNext;
            wgrantReg <= wgrantNext;
            stackReg  <= stackNext;
        end
    end

    assign cpuMode      = modeReg;
    assign segTableAddr = tblReg;
    assign sfrRdata     = rdReg;
    assign sfrDenied    = denReg;
    assign memGrant     = grantReg;
    assign memWrGrant   = wgrantReg;

    chk_user_no_tbl: assert property (@(posedge mclk) disable iff (!nrst)
        (modeReg == cmg_pkg::MODE_USER && sfrWr && sfrAddr == cmg_pkg::SFR_TBL_LOW)
        |=> $stable(tblReg)) else $error("user wrote table pointer");
    chk_cl_no_tbl: assert property (@(posedge mclk) disable iff (!nrst)
        (modeReg == cmg_pkg::MODE_CONTACTLESS && sfrWr
            && (sfrAddr == cmg_pkg::SFR_TBL_LOW || sfrAddr == cmg_pkg::SFR_TBL_HIGH))
        |=> $stable(tblReg)) else $error("contactless wrote table pointer");
    chk_sys_tbl_wr: assert property (@(posedge mclk) disable iff (!nrst)
        (modeReg == cmg_pkg::MODE_SYSTEM && sfrWr && !retInstr && sfrAddr == cmg_pkg::SFR_TBL_LOW)
        |=> tblReg[7:0] == $past(sfrWdata)) else $error("system table write lost");
    chk_denied_zero: assert property (@(posedge mclk) disable iff (!nrst)
        (sfrRd && !canRd) |=> (sfrRdata == 8'h00 && sfrDenied))
        else $error("denied read not zero");
    chk_cl_partition: assert property (@(posedge mclk) disable iff (!nrst)
        (memReq && modeReg == cmg_pkg::MODE_CONTACTLESS && memAddr > cmg_pkg::PART_CL_HI)
        |=> !memGrant) else $error("contactless left partition");
    chk_exc_system: assert property (@(posedge mclk) disable iff (!nrst)
        (excEntry && !retInstr) |=> cpuMode == 3'(cmg_pkg::MODE_SYSTEM))
        else $error("exception did not change mode");
    chk_ret_restore: assert property (@(posedge mclk) disable iff (!nrst)
        (modeReg == cmg_pkg::MODE_USER && excEntry && !retInstr)
        ##1 (!retInstr && !excEntry && !callValid) ##1 retInstr
        |=> cpuMode == 3'(cmg_pkg::MODE_USER)) else $error("return did not restore mode");
    chk_status_read: assert property (@(posedge mclk) disable iff (!nrst)
        (sfrRd && sfrAddr == cmg_pkg::SFR_STATUS_HIGH) |=> !sfrDenied)
        else $error("status-high read denied");
    chk_user_seg_wr: assert property (@(posedge mclk) disable iff (!nrst)
        (memReq && memWr && modeReg == cmg_pkg::MODE_USER && !segAllowWr) |=> !memWrGrant)
        else $error("user write without segment right");

endmodule

`default_nettype wire

//--- pkg/cmg_pkg.sv
// Constants and types shared by the CPU mode and access guard
package cmg_pkg;

    // CPU modes
    typedef enum logic [2:0] {
        MODE_BOOT,
        MODE_TEST,
        MODE_CONTACTLESS,
        MODE_SYSTEM,
        MODE_USER
    } cmg_mode_type;

    // Register groups of the special-function space
    typedef enum logic [2:0] {
        GRP_CPU,
        GRP_SEGCFG,
        GRP_SYSMGMT,
        GRP_HWCOMP,
        GRP_NONE
    } cmg_group_type;

    localparam int          SFR_AW           = 8;
    localparam int          ADDR_W           = 16;
    localparam int          TBL_W            = 16;
    localparam int          STACK_D          = 4;

    // Fixed special-function register addresses
    localparam logic [7:0]  SFR_STATUS_HIGH  = 8'h98;
    localparam logic [7:0]  SFR_TBL_LOW      = 8'hA1;
    localparam logic [7:0]  SFR_TBL_HIGH     = 8'hA2;
    localparam logic [7:0]  SFR_CPU_LO       = 8'h80;
    localparam logic [7:0]  SFR_CPU_HI       = 8'h8F;
    localparam logic [7:0]  SFR_SYS_LO       = 8'h90;
    localparam logic [7:0]  SFR_SYS_HI       = 8'h9F;
    localparam logic [7:0]  SFR_HW_LO        = 8'hC0;
    localparam logic [7:0]  SFR_HW_HI        = 8'hFF;

    // Mode field inside the status-high register
    localparam int          MODE_POS         = 0;

    // Fixed memory partition for contactless mode
    localparam logic [15:0] PART_CL_LO       = 16'h0000;
    localparam logic [15:0] PART_CL_HI       = 16'h0FFF;

    // Reserved call targets and vector range
    localparam logic [15:0] SYSTEM_VECTOR_ADDRESS_LO          = 16'hFF00;
    localparam logic [15:0] SYSTEM_VECTOR_ADDRESS_HI          = 16'hFF7F;
    localparam logic [15:0] SCALL_A          = 16'hFF80;
    localparam logic [15:0] SCALL_B          = 16'hFF84;

    // Restrictive reset values
    localparam logic [15:0] TBL_RESET        = 16'h0000;
    localparam logic [7:0]  STATUS_RESET     = 8'h03;
    localparam logic [2:0]  MODE_RESET_CODE  = 3'h3;
    localparam logic [7:0]  ZERO_BYTE        = 8'h00;

endpackage

//--- verification/cmg_cpu_model.sv
// CPU core model issuing register, memory and mode-event requests
`timescale 1ns/1ps
`default_nettype none
module cmg_cpu_model (
    // Clock
    input  wire logic        mclk,
    // Register requests
    output logic             sfrRd,
    output logic             sfrWr,
    output logic [7:0]       sfrAddr,
    output logic [7:0]       sfrWdata,
    // Memory requests and segment rights
    output logic             memReq,
    output logic             memWr,
    output logic [15:0]      memAddr,
    output logic             segAllowRd,
    output logic             segAllowWr,
    output logic             segAllowHw,
    // Mode events
    output logic             callValid,
    output logic [15:0]      callTarget,
    output logic             excEntry,
    output logic             retInstr
);
    // Idle at time zero
    initial begin
        {sfrRd, sfrWr, memReq, memWr, callValid, excEntry, retInstr} = '0;
        {segAllowRd, segAllowWr, segAllowHw} = '0;
        {sfrAddr, sfrWdata, memAddr, callTarget} = '0;
    end
    // One register access; address and data scrambled once released
    task automatic sfr(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        #1;
        {sfrWr, sfrRd, sfrAddr, sfrWdata} = {wr, !wr, a, d};
        @(posedge mclk);
        #1;
        {sfrWr, sfrRd, sfrAddr, sfrWdata} = {2'b00, ~a, ~d};
    endtask
    // One memory access with the rights of the current segment
    task automatic mem(input logic wr, input logic [15:0] a, input logic rw);
        @(posedge mclk);
        #1;
        {memReq, memWr, memAddr} = {1'b1, wr, a};
        {segAllowRd, segAllowWr, segAllowHw} = {1'b1, rw, rw};
        @(posedge mclk);
        #1;
        {memReq, memWr, memAddr} = {2'b00, ~a};
    endtask
    // Mode event: 0 exception entry, 1 return, 2 call
    task automatic evt(input int k, input logic [15:0] t);
        @(posedge mclk);
        #1;
        {excEntry, retInstr, callValid, callTarget} = {k == 0, k == 1, k == 2, t};
        @(posedge mclk);
        #1;
        {excEntry, retInstr, callValid, callTarget} = {3'b000, ~t};
    endtask
endmodule
`default_nettype wire

//--- verification/cmg_guard_tb.sv
// Self-checking bench for the CPU mode and access guard
`timescale 1ns/1ps
`default_nettype none
module cmg_guard_tb;
    // Short names for the fixed register addresses
    localparam logic [7:0] SH = cmg_pkg::SFR_STATUS_HIGH;
    localparam logic [7:0] TL = cmg_pkg::SFR_TBL_LOW;
    localparam logic [7:0] TH = cmg_pkg::SFR_TBL_HIGH;
    // Design signals
    logic        mclk, nrst, sfrRd, sfrWr, sfrDenied, memReq, memWr, memGrant, memWrGrant;
    logic        segAllowRd, segAllowWr, segAllowHw, callValid, excEntry, retInstr;
    logic [7:0]  sfrAddr, sfrWdata, sfrRdata, rnd;
    logic [15:0] memAddr, callTarget, segTableAddr, tbl, tgt;
    logic [2:0]  cpuMode;
    // Reference model and bookkeeping
    int          miscompares = 0;
    int          totalChecks = 0;
    int          cycles = 0;
    int          seed = 32'hc52e_e7c9;
    int          mode;
    int          stk[$];

    cmg_guard cmg_guard_inst (.mclk, .nrst, .sfrRd, .sfrWr, .sfrAddr, .sfrWdata, .sfrRdata,
        .sfrDenied, .memReq, .memWr, .memAddr, .segAllowRd, .segAllowWr, .segAllowHw,
        .memGrant, .memWrGrant, .callValid, .callTarget, .excEntry, .retInstr, .cpuMode,
        .segTableAddr);
    cmg_cpu_model cmg_cpu_model_inst (.mclk, .sfrRd, .sfrWr, .sfrAddr, .sfrWdata, .memReq,
        .memWr, .memAddr, .segAllowRd, .segAllowWr, .segAllowHw, .callValid, .callTarget,
        .excEntry, .retInstr);

    // Clock
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    // Hang guard
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 1000) begin
            miscompares++;
            closeOut();
        end
    end
    // Value compare
    task automatic cmp(input string what, input logic [15:0] e, input logic [15:0] g);
        totalChecks++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, e, g);
        end
    endtask
    // Mode and table outputs against the model
    task automatic chkState();
        cmp("cpuMode", 16'(mode), 16'(cpuMode));
        cmp("segTableAddr", tbl, segTableAddr);
    endtask
    // Register access; boot, test and system reach all, status-high readable by all
    task automatic regAcc(input logic wr, input logic [7:0] a, input logic [7:0] d);
        logic ok;
        logic [7:0] e;
        ok = (mode == 0 || mode == 1 || mode == 3) || (a == SH && !wr);
        e = (a == TL) ? tbl[7:0] : tbl[15:8];
        cmg_cpu_model_inst.sfr(wr, a, d);
        if (wr && ok && a == SH) mode = int'(d[2:0]);
        else if (wr && ok && a == TL) tbl[7:0] = d;
        else if (wr && ok) tbl[15:8] = d;
        cmp("sfrDenied", 16'(!ok), 16'(sfrDenied));
        if (!wr && ok && a == SH) cmp("modeField", 16'(mode), 16'(sfrRdata[2:0]));
        else if (!wr) cmp("sfrRdata", ok ? 16'(e) : 16'h0000, 16'(sfrRdata));
        chkState();
    endtask
    // Memory access with an expected grant
    task automatic memAcc(input logic wr, input logic [15:0] a, input logic rw, input logic e);
        cmg_cpu_model_inst.mem(wr, a, rw);
        cmp(wr ? "memWrGrant" : "memGrant", 16'(e), 16'(wr ? memWrGrant : memGrant));
    endtask
    // Mode event; exception entry and reserved call targets enter system mode
    task automatic ev(input int k, input logic [15:0] t);
        logic hit;
        hit = (t >= cmg_pkg::SYSTEM_VECTOR_ADDRESS_LO && t <= cmg_pkg::SYSTEM_VECTOR_ADDRESS_HI)
            || t == cmg_pkg::SCALL_A || t == cmg_pkg::SCALL_B;
        cmg_cpu_model_inst.evt(k, t);
        if (k == 1) begin
            mode = stk.pop_back();
        end else if (k == 0 || hit) begin
            stk.push_back(mode);
            mode = 3;
        end
        chkState();
    endtask
    // Verdict
    task automatic closeOut();
        $display("checks %0d, miscompares %0d", totalChecks, miscompares);
        if (miscompares == 0 && totalChecks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // Main sequence
    initial begin
        nrst = 1'b0;
        mode = 3;
        tbl = 16'h0000;
        repeat (5) @(posedge mclk);
        #1;
        nrst = 1'b1;
        chkState();
        for (int i = 0; i < 2; i++) begin
            rnd = 8'($random(seed));
            regAcc(1'b1, i ? TH : TL, rnd);
            regAcc(1'b0, i ? TH : TL, 8'h00);
        end
        regAcc(1'b1, SH, 8'h04);
        regAcc(1'b0, SH, 8'h00);
        regAcc(1'b1, TL, ~rnd);
        regAcc(1'b0, TH, 8'h00);
        regAcc(1'b1, SH, 8'h03);
        for (int w = 0; w < 2; w++) memAcc(1'b1, 16'h2000 + 16'(rnd), w[0], w[0]);
        ev(0, 16'h0000);
        ev(1, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            tgt = (i == 0) ? cmg_pkg::SYSTEM_VECTOR_ADDRESS_LO + 16'($random(seed) & 32'h7f) :
                  (i == 1) ? cmg_pkg::SCALL_A : (i == 2) ? cmg_pkg::SCALL_B : 16'h1234;
            ev(2, tgt);
            if (i < 3) ev(1, 16'h0000);
        end
        ev(0, 16'h0000);
        regAcc(1'b1, SH, 8'h01);
        regAcc(1'b1, TL, ~rnd);
        regAcc(1'b1, SH, 8'h00);
        memAcc(1'b1, 16'h0800, 1'b0, 1'b1);
        regAcc(1'b1, SH, 8'h02);
        regAcc(1'b0, SH, 8'h00);
        regAcc(1'b1, TL, rnd);
        for (int i = 0; i < 6; i++) begin
            tgt = (i < 3) ? 16'($random(seed)) & 16'h1fff : 16'($random(seed));
            memAcc(1'b0, tgt, 1'b1, tgt <= cmg_pkg::PART_CL_HI);
        end
        nrst = 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        nrst = 1'b1;
        mode = 3;
        tbl = 16'h0000;
        stk.delete();
        chkState();
        regAcc(1'b0, TL, 8'h00);
        closeOut();
    end
endmodule
`default_nettype wire
